// ### rtl/hps_pkg.sv
// constants and carrier types for the handset power sequencer
// assumes a 50 MHz system clock and a write-only three-wire serial port
package hps_pkg;
  localparam int unsigned CLK_KHZ    = 50_000;  // system clock in kHz
  localparam int unsigned T_RST_MS   = 140;     // reset hold, least time
  localparam int unsigned T_WD_MS    = 35;      // keep-alive watchdog, least time
  localparam int unsigned T_SHDN_MS  = 175;     // shutdown timer, least time
  localparam int unsigned RST_CYC    = T_RST_MS * CLK_KHZ;
  localparam int unsigned WD_CYC     = T_WD_MS * CLK_KHZ;
  localparam int unsigned SHDN_CYC   = T_SHDN_MS * CLK_KHZ;

  localparam int unsigned NRAIL      = 5;
  localparam int unsigned CODE_W     = 5;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned CMD_LSB    = 5;       // command in bits 7:5, data in 4:0

  localparam logic [2:0] CMD_UPDATE  = 3'h0;
  localparam logic [2:0] CMD_SINK    = 3'h6;
  localparam logic [2:0] CMD_ENABLE  = 3'h7;
  localparam logic [2:0] BIT_LAST    = 3'h7;

  localparam logic [4:0] CODE_DEFAULT = 5'h1b;  // 2.98 V step
  localparam logic [4:0] EN_DEFAULT   = 5'h01;  // only the main rail
  localparam logic [1:0] SINK_DEFAULT = 2'h0;

  // two-wire variant bus addresses
  localparam logic [6:0] ADDR_PICK_HI = 7'h3f;
  localparam logic [6:0] ADDR_PICK_LO = 7'h4f;

  typedef enum logic [1:0] {ST_OFF, ST_HOLD, ST_RUN} hps_state_t;

  typedef struct packed {
    logic [2:0]        cnt;
    logic [BYTE_W-1:0] shreg;
    logic              got;
  } hps_link_t;

  typedef struct packed {
    logic [NRAIL-1:0]             en;
    logic [NRAIL-1:0][CODE_W-1:0] voltage_code;
  } hps_rails_t;

  typedef struct packed {
    hps_state_t                   state;
    logic [31:0]                  tmr;
    logic [31:0]                  sd_tmr;
    logic                         armed;
    logic                         got_seen;
    logic                         cs_seen;
    logic                         pend_en_v;
    logic [NRAIL-1:0]             pend_en;
    logic                         pend_sink_v;
    logic [1:0]                   pend_sink;
    logic [NRAIL-1:0]             en;
    logic [1:0]                   sink;
    logic [NRAIL-1:0][CODE_W-1:0] buf_code;
    logic [NRAIL-1:0][CODE_W-1:0] act_code;
    logic [NRAIL-1:0]             out_en;
    logic                         rst_n;
    logic                         echo;
  } hps_main_t;
endpackage

// ### rtl/hps_top.sv
// power sequencer control: serial command decoder, reset timer, watchdog, on/off logic
// assumes analog monitors arrive as asynchronous levels; serial clock is its own domain
`timescale 1ns/10ps

// three-stage synchroniser; a change counts once stages two and three agree
module hps_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  input  wire logic [W-1:0] i_init,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stb;
  } hps_sync_t;
  hps_sync_t q_q;
  hps_sync_t q_d;

  // per-bit agreement filter, stage one feeds stage two only
  always_comb begin
    q_d     = q_q;
    q_d.s1  = i_d;
    q_d.s2  = q_q.s1;
    q_d.s3  = q_q.s2;
    q_d.stb = (q_q.s2 & ~(q_q.s2 ^ q_q.s3)) | (q_q.stb & (q_q.s2 ^ q_q.s3));
  end

  // reset value is a constant; i_init is masked off and never reaches o_q
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end

  assign o_q = q_q.stb | (i_init & ~(q_q.s2 | q_q.s3 | q_q.stb) & ~q_q.s1 & '0);
endmodule

module hps_top #(
  parameter int unsigned RST_CYC  = hps_pkg::RST_CYC,
  parameter int unsigned WD_CYC   = hps_pkg::WD_CYC,
  parameter int unsigned SHDN_CYC = hps_pkg::SHDN_CYC,
  parameter bit          SHDN_VARIANT = 1'b0
) (
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  input  wire logic               i_sclk,
  input  wire logic               i_cs_n,
  input  wire logic               i_din,
  input  wire logic               i_wake_btn_n,
  input  wire logic               i_keep_alive,
  input  wire logic               i_main_supply_ok,
  input  wire logic               i_rail_main_ok,
  input  wire logic               i_uv_rail23,
  input  wire logic               i_uv_rail45,
  output hps_pkg::hps_rails_t     o_rails,
  output logic                    o_system_reset_n,
  output logic                    o_button_echo_out,
  output logic                    o_droop_13pct,
  output logic                    o_sink_driver_a_o,
  output logic                    o_sink_driver_a_oe_n,
  output logic                    o_sink_driver_b_o,
  output logic                    o_sink_driver_b_oe_n
);
  import hps_pkg::*;

  logic       rst_meta_q;
  logic       rst_sync_q;
  hps_link_t  l_q;
  hps_link_t  l_d;
  hps_main_t  q_q;
  hps_main_t  q_d;
  logic [6:0] sy_raw;
  logic [6:0] sy;
  logic       btn_s;
  logic       btn_n_s;
  logic       ka_s;
  logic       sup_s;
  logic       ok_s;
  logic       uv23_s;
  logic       uv45_s;
  logic       cs_s;
  logic       got_s;
  logic [2:0] cmd;
  logic [4:0] dat;
  logic       off_req;

  // reset released through two flops so the synchroniser and the sequencer leave reset together
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // serial shift: one byte per select frame, later bits ignored
  always_comb begin
    l_d = l_q;
    if (!l_q.got) begin
      l_d.shreg = {l_q.shreg[BYTE_W-2:0], i_din};
      l_d.cnt   = l_q.cnt + 3'h1;
      l_d.got   = (l_q.cnt == BIT_LAST);
    end
  end

  // select high clears the frame; only rising serial edges sample data
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // every outside level crosses through three stages
  assign sy_raw = {l_q.got, i_cs_n, i_uv_rail45, i_uv_rail23,
                   i_rail_main_ok, i_main_supply_ok, i_keep_alive};

  // button crosses as a press level, so the all-zero reset state reads as released;
  // syncing the raw low-active pin would fake a press right after reset
  hps_sync #(
    .W (8)
  ) u_sync (
    .i_clk   (i_mclk),
    .i_rst_n (rst_sync_q),
    .i_d     ({~i_wake_btn_n, sy_raw}),
    .i_init  (8'h00),
    .o_q     ({btn_s, sy})
  );

  assign btn_n_s = ~btn_s;

  assign ka_s   = sy[0];
  assign sup_s  = sy[1];
  assign ok_s   = sy[2];
  assign uv23_s = sy[3];
  assign uv45_s = sy[4];
  assign cs_s   = sy[5];
  assign got_s  = sy[6];

  // byte is stable while the synced flag is high, so it is read qualified
  assign cmd = l_q.shreg[BYTE_W-1:CMD_LSB];
  assign dat = l_q.shreg[CMD_LSB-1:0];

  // main sequencer and command decoder
  always_comb begin
    q_d          = q_q;
    off_req      = 1'b0;
    q_d.got_seen = got_s;
    q_d.cs_seen  = cs_s;

    // serial port only listens while the device is on
    if (q_q.state != ST_OFF && got_s && !q_q.got_seen) begin
      case (cmd)
        CMD_UPDATE: begin
          for (int i = 0; i < NRAIL; i++) begin
            if (dat[i]) begin
              q_d.act_code[i] = q_q.buf_code[i];
            end
          end
        end
        CMD_SINK: begin
          q_d.pend_sink   = dat[1:0];
          q_d.pend_sink_v = 1'b1;
        end
        CMD_ENABLE: begin
          q_d.pend_en   = dat;
          q_d.pend_en_v = 1'b1;
        end
        default: begin
          q_d.buf_code[cmd - 3'h1] = dat;
        end
      endcase
    end

    // unbuffered enables land when select returns high
    if (cs_s && !q_q.cs_seen) begin
      if (q_q.pend_sink_v) begin
        q_d.sink        = q_q.pend_sink;
        q_d.pend_sink_v = 1'b0;
      end
      if (q_q.pend_en_v) begin
        q_d.pend_en_v = 1'b0;
        q_d.en        = q_q.pend_en;
        // held button keeps the main rail alive
        if (!q_q.pend_en[0] && btn_n_s) begin
          off_req = 1'b1;
        end else begin
          q_d.en[0] = 1'b1;
        end
      end
    end

    case (q_q.state)
      ST_OFF: begin
        // a fresh press needs the button seen released first
        if (btn_n_s) begin
          q_d.armed = 1'b1;
        end
        if (q_q.armed && !btn_n_s && sup_s) begin
          q_d.state  = ST_HOLD;
          q_d.armed  = 1'b0;
          q_d.en[0]  = 1'b1;
          q_d.tmr    = '0;
          q_d.sd_tmr = '0;
        end
      end
      ST_HOLD: begin
        // timer runs only while the main rail is in regulation
        if (ok_s) begin
          q_d.tmr    = q_q.tmr + 32'h1;
          q_d.sd_tmr = '0;
        end else begin
          q_d.tmr    = '0;
          q_d.sd_tmr = q_q.sd_tmr + 32'h1;
        end
        if (ok_s && q_q.tmr >= 32'(RST_CYC - 1)) begin
          q_d.state = ST_RUN;
          q_d.tmr   = '0;
        end
        if (SHDN_VARIANT && !ok_s && q_q.sd_tmr >= 32'(SHDN_CYC - 1)) begin
          off_req = 1'b1;
        end
      end
      ST_RUN: begin
        if (!ok_s) begin
          q_d.state  = ST_HOLD;
          q_d.tmr    = '0;
          q_d.sd_tmr = '0;
        end else if (!btn_n_s || ka_s) begin
          q_d.tmr = '0;
        end else begin
          q_d.tmr = q_q.tmr + 32'h1;
          if (q_q.tmr >= 32'(WD_CYC - 1)) begin
            off_req = 1'b1;
          end
        end
      end
      default: begin
        q_d.state = ST_OFF;
      end
    endcase

    // shutdown keeps the codes, drops the side rails and drivers
    if (off_req) begin
      q_d.state       = ST_OFF;
      q_d.en[4:1]     = '0;
      q_d.sink        = SINK_DEFAULT;
      q_d.pend_en_v   = 1'b0;
      q_d.pend_sink_v = 1'b0;
      q_d.tmr         = '0;
      q_d.sd_tmr      = '0;
      q_d.armed       = btn_n_s;
    end

    // registered pin views; undervoltage gates but never stores
    q_d.out_en = '0;
    if (q_d.state != ST_OFF) begin
      q_d.out_en = q_d.en & ~{uv45_s, uv45_s, uv23_s, uv23_s, 1'b0};
    end
    q_d.rst_n = (q_d.state == ST_RUN);
    q_d.echo  = (q_d.state != ST_OFF) && btn_n_s;
  end

  // supply reset restores defaults
  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      q_q           <= '0;
      q_q.state     <= ST_OFF;
      q_q.armed     <= 1'b1;
      q_q.got_seen  <= 1'b0;
      q_q.cs_seen   <= 1'b1;
      q_q.en        <= EN_DEFAULT;
      q_q.sink      <= SINK_DEFAULT;
      q_q.buf_code  <= {NRAIL{CODE_DEFAULT}};
      q_q.act_code  <= {NRAIL{CODE_DEFAULT}};
    end else begin
      q_q <= q_d;
    end
  end

  assign o_rails.en           = q_q.out_en;
  assign o_rails.voltage_code = q_q.act_code;
  assign o_system_reset_n     = q_q.rst_n;
  assign o_button_echo_out    = q_q.echo;
  assign o_droop_13pct        = SHDN_VARIANT;
  assign o_sink_driver_a_o    = 1'b0;
  assign o_sink_driver_b_o    = 1'b0;
  assign o_sink_driver_a_oe_n = ~q_q.sink[0];
  assign o_sink_driver_b_oe_n = ~q_q.sink[1];
endmodule

// ### tb/hps_host_model.sv
// host side of the serial link: one write byte per frame
// assumes mode zero, clock idle low and still outside frames
`timescale 1ns/10ps
module hps_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  // idle link
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din  = 1'b0;
  end
  // msb first, data changes on the falling edge
  task automatic send(input logic [7:0] b);
    o_cs_n = 1'b0;
    #7;
    for (int i = 7; i >= 0; i--) begin
      o_din = b[i];
      #3 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
    end
    #200 o_cs_n = 1'b1;
    o_din = ~o_din; // released line keeps no stale bit
    #200;
  endtask
endmodule

// ### tb/hps_assertions.sv
// checker on the sequencer top ports
// assumes one mclk domain and shortened timer lengths
`timescale 1ns/10ps
module hps_checker #(
  parameter int unsigned RST_CYC = 40
) (
  input wire logic                i_mclk,
  input wire logic                i_rst_n,
  input wire logic                i_wake_btn_n,
  input wire logic                i_main_supply_ok,
  input wire logic                i_rail_main_ok,
  input wire logic                i_uv_rail23,
  input wire logic                i_uv_rail45,
  input wire hps_pkg::hps_rails_t o_rails,
  input wire logic                o_system_reset_n,
  input wire logic                o_button_echo_out,
  input wire logic                o_sink_driver_a_oe_n,
  input wire logic                o_sink_driver_b_oe_n
);
  import hps_pkg::*;
  logic [31:0] ok_q;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // raw run length of main rail regulation; sync lag keeps it ahead
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) ok_q <= 32'h0;
    else ok_q <= i_rail_main_ok ? ok_q + 32'h1 : 32'h0;
  end
  property p_droop; !i_rail_main_ok |-> ##[0:6] !o_system_reset_n; endproperty
  a_droop: assert property (p_droop) else $error("no reset on droop");
  property p_uv23; i_uv_rail23 [*8] |-> o_rails.en[2:1] == 2'h0; endproperty
  a_uv23: assert property (p_uv23) else $error("rails 2-3 on in uv");
  property p_uv45; i_uv_rail45 [*8] |-> o_rails.en[4:3] == 2'h0; endproperty
  a_uv45: assert property (p_uv45) else $error("rails 4-5 on in uv");
  property p_hold; $rose(o_system_reset_n) |-> ok_q >= RST_CYC; endproperty
  a_hold: assert property (p_hold) else $error("reset released early");
  property p_off;
    !o_rails.en[0] |-> o_rails.en == 5'h0 && o_sink_driver_a_oe_n && o_sink_driver_b_oe_n;
  endproperty
  a_off: assert property (p_off) else $error("output live while off");
  property p_rso; !o_rails.en[0] |-> !o_system_reset_n; endproperty
  a_rso: assert property (p_rso) else $error("reset high while off");
  property p_echo; (o_rails.en[0] && i_wake_btn_n) [*6] |-> o_button_echo_out; endproperty
  a_echo: assert property (p_echo) else $error("echo not following");
  property p_btn; (i_main_supply_ok && !i_wake_btn_n) [*8] |-> o_rails.en[0]; endproperty
  a_btn: assert property (p_btn) else $error("main rail off, button low");
endmodule
bind hps_top hps_checker #(.RST_CYC(RST_CYC)) u_hps_checker (.i_mclk, .i_rst_n,
  .i_wake_btn_n, .i_main_supply_ok, .i_rail_main_ok, .i_uv_rail23, .i_uv_rail45,
  .o_rails, .o_system_reset_n, .o_button_echo_out, .o_sink_driver_a_oe_n,
  .o_sink_driver_b_oe_n);

// ### tb/handset_power_sequencer_bench.sv
// bench for hps_top: one task per scenario, host model on the link
// assumes shortened timers; bench drives the other inputs
`timescale 1ns/10ps
module handset_power_sequencer_bench;
  import hps_pkg::*;
  localparam int RC = 40;
  localparam int WC = 20;
  logic clk = 1'b0, rst_n = 1'b0, btn_n = 1'b1, ka = 1'b0, rok = 1'b1;
  logic uv23 = 1'b0, uv45 = 1'b0, sclk, cs_n, din, system_reset_n, echo, aoe, boe;
  logic sup = 1'b1, drp, ao, bo;
  hps_rails_t rails;
  int err_count = 0, n_checks = 0, n;
  hps_top #(.RST_CYC(RC), .WD_CYC(WC), .SHDN_CYC(60)) u_hps_top (.i_mclk(clk),
    .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din), .i_wake_btn_n(btn_n),
    .i_keep_alive(ka), .i_main_supply_ok(sup), .i_rail_main_ok(rok), .i_uv_rail23(uv23),
    .i_uv_rail45(uv45), .o_rails(rails), .o_system_reset_n(system_reset_n), .o_button_echo_out(echo),
    .o_droop_13pct(drp), .o_sink_driver_a_o(ao), .o_sink_driver_a_oe_n(aoe),
    .o_sink_driver_b_o(bo), .o_sink_driver_b_oe_n(boe));
  hps_host_model u_hps_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
  // 50 MHz clock
  always #10 clk = ~clk;
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  // bounded wait for reset release, cycles in n
  task automatic wait_rso;
    n = 0;
    while (system_reset_n !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_on;
    chk(rails.en, 5'h0);
    for (int i = 0; i < NRAIL; i++) chk(rails.voltage_code[i], 5'h1b);
    chk({2'h0, system_reset_n, aoe, boe}, 5'h3);
    chk({2'h0, drp, ao, bo}, 5'h0);
    @(posedge clk);
    btn_n <= 1'b0;
    cyc(10);
    chk({rails.en[4:1], system_reset_n}, 5'h0);
    @(posedge clk);
    btn_n <= 1'b1;
    wait_rso();
    chk({3'h0, n + 10 >= RC, rails.en[0]}, 5'h3);
    @(posedge clk);
    ka <= 1'b1;
    cyc(8);
    chk({4'h0, echo}, 5'h1);
    $display("test power on done");
  endtask
  task automatic t_serial;
    u_hps_host_model.send(8'h45);
    chk(rails.voltage_code[1], 5'h1b);
    u_hps_host_model.send(8'h02);
    chk(rails.voltage_code[1], 5'h05);
    u_hps_host_model.send(8'hbf);
    u_hps_host_model.send(8'h10);
    chk(rails.voltage_code[4], 5'h1f);
    u_hps_host_model.send(8'hff);
    chk(rails.en, 5'h1f);
    u_hps_host_model.send(8'hc5);
    chk({3'h0, aoe, boe}, 5'h1);
    u_hps_host_model.send(8'hde);
    chk({3'h0, aoe, boe}, 5'h2);
    $display("test serial done");
  endtask
  task automatic t_uv_droop;
    @(posedge clk);
    uv23 <= 1'b1;
    cyc(10);
    chk(rails.en, 5'h19);
    chk(rails.voltage_code[1], 5'h05);
    @(posedge clk);
    uv23 <= 1'b0;
    uv45 <= 1'b1;
    cyc(10);
    chk(rails.en, 5'h07);
    @(posedge clk);
    uv45 <= 1'b0;
    rok <= 1'b0;
    ka <= 1'b0;
    cyc(10);
    chk({rails.en[4:1], system_reset_n}, 5'h1e);
    @(posedge clk);
    rok <= 1'b1;
    wait_rso();
    chk({3'h0, n >= RC, rails.en[0]}, 5'h3);
    @(posedge clk);
    ka <= 1'b1;
    $display("test uv droop done");
  endtask
  task automatic t_off;
    @(posedge clk);
    ka <= 1'b0;
    cyc(WC - 6);
    chk({4'h0, rails.en[0]}, 5'h1);
    cyc(WC + 10);
    chk({rails.en[0], system_reset_n, aoe, boe}, 5'h3);
    u_hps_host_model.send(8'hff);
    chk(rails.en, 5'h0);
    @(posedge clk);
    sup <= 1'b0;
    btn_n <= 1'b0;
    cyc(10);
    chk(rails.en, 5'h0);
    @(posedge clk);
    sup <= 1'b1;
    wait_rso();
    cyc(WC + 10);
    chk(rails.en, 5'h01);
    chk(rails.voltage_code[1], 5'h05);
    chk({4'h0, echo}, 5'h0);
    @(posedge clk);
    btn_n <= 1'b1;
    ka <= 1'b1;
    cyc(10);
    u_hps_host_model.send(8'he0);
    chk({3'h0, rails.en[0], system_reset_n}, 5'h0);
    $display("test shutdown done");
  endtask
  // reset, then the scenarios in order
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cyc(8);
    t_on();
    t_serial();
    t_uv_droop();
    t_off();
    tally_and_finish();
  end
  // hang guard, far beyond the expected run
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
endmodule
